// ---- rtl/pin_mux.sv ----
// Peripheral pin multiplexer for five port controllers and trace port
`timescale 1ns/1ps
`default_nettype none
`include "pinmux_cfg.svh"

////////////////////////////////////////////////////////////////////////
module pin_mux #(
  parameter int                  LINES      = `PORT_LINES,
  parameter logic [`PORT_COUNT*`PORT_LINES-1:0] RESET_PULL = '1
) (
  // Clock and reset
  input  wire logic                             core_clk,
  input  wire logic                             rst_n,
  // Port controllers, one row per port A..E
  input  wire logic [`PORT_COUNT-1:0][LINES-1:0] gpio_out,
  input  wire logic [`PORT_COUNT-1:0][LINES-1:0] gpio_oe,
  input  wire logic [`PORT_COUNT-1:0][LINES-1:0] pull_req,
  input  wire logic [`PORT_COUNT-1:0][LINES-1:0] func_sel_b,
  input  wire logic [`PORT_COUNT-1:0][LINES-1:0] periph_en,
  // Port A peripherals, indexed by function code
  input  wire logic [`FUNC_COUNT-1:0]           port_a_func_out,
  input  wire logic [`FUNC_COUNT-1:0]           port_a_func_oe,
  output logic      [`FUNC_COUNT-1:0]           port_a_func_in,
  // Ports B..E peripherals, one row per port
  input  wire logic [`PORT_COUNT-2:0][LINES-1:0] bcde_func_a_out,
  input  wire logic [`PORT_COUNT-2:0][LINES-1:0] bcde_func_a_oe,
  input  wire logic [`PORT_COUNT-2:0][LINES-1:0] bcde_func_b_out,
  input  wire logic [`PORT_COUNT-2:0][LINES-1:0] bcde_func_b_oe,
  // Debug trace port
  input  wire logic                             trace_en,
  input  wire logic                             trace_layout_select,
  input  wire logic [5:0]                       trace_message_data,
  input  wire logic [1:0]                       trace_message_start_end,
  input  wire logic                             trace_clock_out,
  input  wire logic                             debug_event_out,
  input  wire logic                             debug_event_in_pad,
  output logic                                  debug_event_in,
  // Interrupt inputs taken from pads
  output logic                                  nmi_n,
  output logic      [3:0]                       external_irq_in,
  // Pads
  input  wire logic [`PORT_COUNT-1:0][LINES-1:0] pad_in,
  output logic      [`PORT_COUNT-1:0][LINES-1:0] pad_out,
  output logic      [`PORT_COUNT-1:0][LINES-1:0] pad_oe,
  output logic      [`PORT_COUNT-1:0][LINES-1:0] pull_en,
  output logic      [`PORT_COUNT-1:0][LINES-1:0] line_in
);

  ////////////////////////////////////////////////////////////////////////
  // Port A function table

  // Codes are {select, line}, so the table needs no storage
  // Code of the function a port A line carries under a selection
  function automatic pinmux_pkg::periph_func_e func_code(
    input logic                  sel_b,
    input pinmux_pkg::line_idx_t line
  );
    func_code = pinmux_pkg::periph_func_e'({sel_b, line});
  endfunction

  logic [`PORT_COUNT-1:0][LINES-1:0] fa_out;
  logic [`PORT_COUNT-1:0][LINES-1:0] fa_oe;
  logic [`PORT_COUNT-1:0][LINES-1:0] fb_out;
  logic [`PORT_COUNT-1:0][LINES-1:0] fb_oe;

  always_comb begin
    fa_out = '0;
    fa_oe  = '0;
    fb_out = '0;
    fb_oe  = '0;
    for (int l = 0; l < LINES; l++) begin
      fa_out[`PORT_A][l] = port_a_func_out[func_code(1'b0, 5'(l))];
      fa_oe[`PORT_A][l]  = port_a_func_oe[func_code(1'b0, 5'(l))];
      fb_out[`PORT_A][l] = port_a_func_out[func_code(1'b1, 5'(l))];
      fb_oe[`PORT_A][l]  = port_a_func_oe[func_code(1'b1, 5'(l))];
    end
    // Ports B..E: an A and a B source per line, taken from that port's own row
    for (int p = 1; p < `PORT_COUNT; p++) begin
      fa_out[p] = bcde_func_a_out[p-1];
      fa_oe[p]  = bcde_func_a_oe[p-1];
      fb_out[p] = bcde_func_b_out[p-1];
      fb_oe[p]  = bcde_func_b_oe[p-1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Trace pin override

  logic [`PORT_COUNT-1:0][LINES-1:0] trace_own;
  logic [`PORT_COUNT-1:0][LINES-1:0] trace_val;

  // Port C line of a trace data bit in layout 1; the lines are scattered
  function automatic pinmux_pkg::line_idx_t trace1_line(input int b);
    case (b)
      0:       trace1_line = 5'(`TRC1_DATA0);
      1:       trace1_line = 5'(`TRC1_DATA1);
      2:       trace1_line = 5'(`TRC1_DATA2);
      3:       trace1_line = 5'(`TRC1_DATA3);
      4:       trace1_line = 5'(`TRC1_DATA4);
      5:       trace1_line = 5'(`TRC1_DATA5);
      default: trace1_line = 5'(`TRC1_DATA0);
    endcase
  endfunction

  always_comb begin
    trace_own = '0;
    trace_val = '0;
    // Owned pins drive even where the port asked for an input
    if (trace_en && !trace_layout_select) begin
      for (int b = 0; b < `TRACE_DATA_BITS; b++) begin
        trace_own[`PORT_B][`TRC0_DATA0+b] = 1'b1;
        trace_val[`PORT_B][`TRC0_DATA0+b] = trace_message_data[b];
      end
      trace_own[`PORT_B][`TRC0_EVENT]      = 1'b1;
      trace_val[`PORT_B][`TRC0_EVENT]      = debug_event_out;
      trace_own[`PORT_B][`TRC0_CLOCK]      = 1'b1;
      trace_val[`PORT_B][`TRC0_CLOCK]      = trace_clock_out;
      trace_own[`PORT_B][`TRC0_START_END1] = 1'b1;
      trace_val[`PORT_B][`TRC0_START_END1] = trace_message_start_end[1];
      trace_own[`PORT_B][`TRC0_START_END0] = 1'b1;
      trace_val[`PORT_B][`TRC0_START_END0] = trace_message_start_end[0];
    end else if (trace_en) begin
      for (int b = 0; b < `TRACE_DATA_BITS; b++) begin
        trace_own[`PORT_C][trace1_line(b)] = 1'b1;
        trace_val[`PORT_C][trace1_line(b)] = trace_message_data[b];
      end
      trace_own[`PORT_B][`TRC1_EVENT]      = 1'b1;
      trace_val[`PORT_B][`TRC1_EVENT]      = debug_event_out;
      trace_own[`PORT_C][`TRC1_CLOCK]      = 1'b1;
      trace_val[`PORT_C][`TRC1_CLOCK]      = trace_clock_out;
      trace_own[`PORT_C][`TRC1_START_END1] = 1'b1;
      trace_val[`PORT_C][`TRC1_START_END1] = trace_message_start_end[1];
      trace_own[`PORT_C][`TRC1_START_END0] = 1'b1;
      trace_val[`PORT_C][`TRC1_START_END0] = trace_message_start_end[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-port line multiplexers

  for (genvar p = 0; p < `PORT_COUNT; p++) begin : g_port
    port_lane_mux #(
      .WIDTH      (LINES),
      .RESET_PULL (RESET_PULL[p*LINES +: LINES])
    ) u_lane (
      .core_clk   (core_clk),
      .rst_n      (rst_n),
      .func_sel_b (func_sel_b[p]),
      .periph_en  (periph_en[p]),
      .gpio_out   (gpio_out[p]),
      .gpio_oe    (gpio_oe[p]),
      .pull_req   (pull_req[p]),
      .func_a_out (fa_out[p]),
      .func_a_oe  (fa_oe[p]),
      .func_b_out (fb_out[p]),
      .func_b_oe  (fb_oe[p]),
      .trace_own  (trace_own[p]),
      .trace_val  (trace_val[p]),
      .pad_in     (pad_in[p]),
      .pad_out    (pad_out[p]),
      .pad_oe     (pad_oe[p]),
      .pull_en    (pull_en[p]),
      .line_in    (line_in[p])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Inputs returned to peripherals

  logic [`FUNC_COUNT-1:0] next_port_a_func_in;
  logic                   next_nmi_n;
  logic [3:0]             next_external_irq_in;
  logic                   next_debug_event_in;

  always_comb begin
    next_port_a_func_in = '0;
    for (int l = 0; l < LINES; l++) begin
      // Unselected functions see a quiet low
      if (periph_en[`PORT_A][l]) begin
        next_port_a_func_in[func_code(func_sel_b[`PORT_A][l], 5'(l))] =
          pad_in[`PORT_A][l];
      end
    end
    // The NMI line is never a trace pin, so it needs no gate
    next_nmi_n = pad_in[`PORT_B][`NMI_LINE];
    for (int k = 0; k < `EXT_IRQ_COUNT; k++) begin
      // A pin held by trace is our own drive, not a request
      next_external_irq_in[k] =
        pad_in[`PORT_B][`EXT_IRQ_LINE0+k] &
        ~trace_own[`PORT_B][`EXT_IRQ_LINE0+k];
    end
    // Dedicated pin, never multiplexed
    next_debug_event_in = debug_event_in_pad;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_a_func_in  <= '0;
      nmi_n           <= 1'b1;
      external_irq_in <= '0;
      debug_event_in  <= 1'b1;
    end else begin
      port_a_func_in  <= next_port_a_func_in;
      nmi_n           <= next_nmi_n;
      external_irq_in <= next_external_irq_in;
      debug_event_in  <= next_debug_event_in;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/pinmux_cfg.svh ----
// Constants for the peripheral pin multiplexer
`ifndef PINMUX_CFG_SVH
`define PINMUX_CFG_SVH

`define PORT_COUNT      5
`define PORT_LINES      32
`define FUNC_COUNT      64
`define PORT_A          0
`define PORT_B          1
`define PORT_C          2

// Trace layout 0: all on port B, consecutive from this line upward
`define TRC0_START_END0 0
`define TRC0_START_END1 1
`define TRC0_CLOCK      2
`define TRC0_EVENT      3
`define TRC0_DATA0      4

// Trace layout 1: mostly port C, event out on port B
`define TRC1_START_END0 0
`define TRC1_START_END1 1
`define TRC1_CLOCK      2
`define TRC1_DATA0      5
`define TRC1_DATA1      6
`define TRC1_DATA2      11
`define TRC1_DATA3      12
`define TRC1_DATA4      14
`define TRC1_DATA5      18
`define TRC1_EVENT      28

// Interrupt inputs on port B
`define NMI_LINE        24
`define EXT_IRQ_LINE0   25

// Trace data width and external interrupt count
`define TRACE_DATA_BITS 6
`define EXT_IRQ_COUNT   4

`endif

// ---- rtl/pinmux_pkg.sv ----
// Types for the peripheral pin multiplexer
package pinmux_pkg;

  typedef logic [4:0] line_idx_t;

  // Port A functions: A functions take codes 0-31 by line, B 32-63
  typedef enum logic [5:0] {
    FN_SPI0_MISO, FN_SPI0_MOSI, FN_SPI0_SCK, FN_SPI0_CS0,
    FN_SPI0_CS1, FN_SPI0_CS2, FN_TWO_WIRE_SDA, FN_TWO_WIRE_SCL,
    FN_PS2_CLK, FN_PS2_DATA, FN_CARD_CLK, FN_CARD_CMD,
    FN_CARD_D0, FN_CARD_D1, FN_CARD_D2, FN_CARD_D3,
    FN_USART1_CLK, FN_USART1_RXD, FN_USART1_TXD, FN_USART1_RTS,
    FN_USART1_CTS, FN_SYNC0_RX_FS, FN_SYNC0_RX_CLK, FN_SYNC0_TX_CLK,
    FN_SYNC0_TX_FS, FN_SYNC0_TXD, FN_SYNC0_RXD, FN_SPI1_CS3,
    FN_PWM0, FN_PWM1, FN_GEN_CLK0, FN_GEN_CLK1,
    FN_SYNC1_RX_FS, FN_SYNC1_TX_FS, FN_SYNC1_TX_CLK, FN_SYNC1_RX_CLK,
    FN_SYNC1_TXD, FN_SYNC1_RXD, FN_USART0_RTS, FN_USART0_CTS,
    FN_USART0_RXD, FN_USART0_TXD, FN_USART0_CLK, FN_TIMER0_CLK0,
    FN_TIMER0_A0, FN_TIMER0_A1, FN_TIMER0_A2, FN_TIMER0_B0,
    FN_TIMER0_B1, FN_TIMER0_B2, FN_TIMER0_CLK2, FN_TIMER0_CLK1,
    FN_SPI0_CS3, FN_PWM2, FN_PWM3, FN_TIMER1_A0,
    FN_TIMER1_A1, FN_TIMER1_B0, FN_TIMER1_B1, FN_TIMER1_CLK0,
    FN_TIMER1_A2, FN_TIMER1_B2, FN_TIMER1_CLK1, FN_TIMER1_CLK2
  } periph_func_e;

endpackage

// ---- rtl/port_lane_mux.sv ----
// One port controller's line multiplexer with registered pad drive
`timescale 1ns/1ps
`default_nettype none

module port_lane_mux #(
  parameter int               WIDTH      = 32,
  parameter logic [WIDTH-1:0] RESET_PULL = '1
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Selection from the port controller
  input  wire logic [WIDTH-1:0] func_sel_b,
  input  wire logic [WIDTH-1:0] periph_en,
  input  wire logic [WIDTH-1:0] gpio_out,
  input  wire logic [WIDTH-1:0] gpio_oe,
  input  wire logic [WIDTH-1:0] pull_req,
  // Peripheral functions
  input  wire logic [WIDTH-1:0] func_a_out,
  input  wire logic [WIDTH-1:0] func_a_oe,
  input  wire logic [WIDTH-1:0] func_b_out,
  input  wire logic [WIDTH-1:0] func_b_oe,
  // Trace override
  input  wire logic [WIDTH-1:0] trace_own,
  input  wire logic [WIDTH-1:0] trace_val,
  // Pads
  input  wire logic [WIDTH-1:0] pad_in,
  output logic      [WIDTH-1:0] pad_out,
  output logic      [WIDTH-1:0] pad_oe,
  output logic      [WIDTH-1:0] pull_en,
  output logic      [WIDTH-1:0] line_in
);

  logic [WIDTH-1:0] next_pad_out;
  logic [WIDTH-1:0] next_pad_oe;

  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      if (trace_own[i]) begin
        next_pad_out[i] = trace_val[i];
        next_pad_oe[i]  = 1'b1;
      end else if (periph_en[i]) begin
        next_pad_out[i] = func_sel_b[i] ? func_b_out[i]
                                        : func_a_out[i];
        next_pad_oe[i]  = func_sel_b[i] ? func_b_oe[i] : func_a_oe[i];
      end else begin
        next_pad_out[i] = gpio_out[i];
        next_pad_oe[i]  = gpio_oe[i];
      end
    end
  end

  // Lines come up as pulled-up inputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_out <= '0;
      pad_oe  <= '0;
      pull_en <= RESET_PULL;
      line_in <= '0;
    end else begin
      pad_out <= next_pad_out;
      pad_oe  <= next_pad_oe;
      pull_en <= pull_req;
      line_in <= pad_in;
    end
  end

endmodule

`default_nettype wire

// ---- test/pad_model.sv ----
// Pads and external parts seen by the multiplexer
`timescale 1ns/1ps
`default_nettype none

module pad_model (
  // Clock
  input  wire logic             core_clk,
  // Device side
  input  wire logic [4:0][31:0] pad_out,
  input  wire logic [4:0][31:0] pad_oe,
  input  wire logic [4:0][31:0] pull_en,
  // External drivers
  input  wire logic [4:0][31:0] ext_en,
  input  wire logic [4:0][31:0] ext_val,
  // Pad levels
  output logic      [4:0][31:0] pad_in
);
  logic [4:0][31:0] last;

  always_ff @(posedge core_clk) begin
    last <= pad_in;
  end
  // Floating unpulled lines toggle so no stale level passes as valid
  always_comb begin
    pad_in = pad_oe & pad_out | ~pad_oe & ext_en & ext_val
           | ~pad_oe & ~ext_en & (pull_en | ~last);
  end
endmodule

`default_nettype wire

// ---- test/pin_mux_chk.sv ----
// Concurrent checks on the pin multiplexer ports
`timescale 1ns/1ps
`default_nettype none

module pin_mux_chk (
  // Clock and reset
  input wire logic                 core_clk,
  input wire logic                 rst_n,
  // Controller and peripheral sources
  input wire logic [4:0][31:0]     gpio_out,
  input wire logic [4:0][31:0]     gpio_oe,
  input wire logic [4:0][31:0]     func_sel_b,
  input wire logic [4:0][31:0]     periph_en,
  input wire logic [63:0]          port_a_func_out,
  input wire logic [3:0][31:0]     bcde_func_a_out,
  input wire logic [3:0][31:0]     bcde_func_b_out,
  // Trace
  input wire logic                 trace_en,
  input wire logic                 trace_layout_select,
  input wire logic [5:0]           trace_message_data,
  input wire logic [1:0]           trace_message_start_end,
  input wire logic                 trace_clock_out,
  input wire logic                 debug_event_out,
  // Pads and inputs
  input wire logic [4:0][31:0]     pad_in,
  input wire logic [4:0][31:0]     pad_out,
  input wire logic [4:0][31:0]     pad_oe,
  input wire logic [4:0][31:0]     pull_en,
  input wire logic [4:0][31:0]     line_in,
  input wire logic                 nmi_n,
  input wire logic [3:0]           external_irq_in
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_RESET_STATE: assert property (
    $rose(rst_n) |-> &pull_en && pad_oe == '0 && nmi_n)
    else $error("outputs not at reset state after release");
  AST_LINE_IN: assert property (
    $past(rst_n) |-> line_in == $past(pad_in))
    else $error("line input not one cycle behind pad");
  AST_GPIO_OWN: assert property (
    $past(rst_n) |-> (((pad_out[3] ^ $past(gpio_out[3]))
    | (pad_oe[3] ^ $past(gpio_oe[3]))) & ~$past(periph_en[3])) == '0)
    else $error("general purpose drive wrong");
  AST_SEL_AB: assert property (
    $past(rst_n) |-> ((pad_out[3] ^ $past(func_sel_b[3] & bcde_func_b_out[2]
    | ~func_sel_b[3] & bcde_func_a_out[2])) & $past(periph_en[3])) == '0)
    else $error("function select wrong");
  AST_PORT_A_FUNC: assert property (
    $past(rst_n) |-> ((pad_out[0] ^ $past(func_sel_b[0]
    & port_a_func_out[63:32] | ~func_sel_b[0] & port_a_func_out[31:0]))
    & $past(periph_en[0])) == '0)
    else $error("port A function wrong");
  AST_TRACE_LAYOUT0: assert property (
    $past(rst_n && trace_en && !trace_layout_select) |-> &pad_oe[1][9:0]
    && pad_out[1][9:0] == $past({trace_message_data, debug_event_out,
    trace_clock_out, trace_message_start_end}))
    else $error("trace layout 0 pins wrong");
  AST_TRACE_LAYOUT1: assert property (
    $past(rst_n && trace_en && trace_layout_select) |-> pad_oe[1][28]
    && {pad_out[2][18], pad_out[2][14], pad_out[2][12], pad_out[2][11],
    pad_out[2][6], pad_out[2][5], pad_out[1][28], pad_out[2][2:0]}
    == $past({trace_message_data, debug_event_out, trace_clock_out,
    trace_message_start_end}))
    else $error("trace layout 1 pins wrong");
  AST_NMI_PIN: assert property (
    $past(rst_n) |-> nmi_n == $past(pad_in[1][24]))
    else $error("nmi not from its pin");
  AST_EXT_IRQ: assert property (
    $past(rst_n && !(trace_en && trace_layout_select))
    |-> external_irq_in == $past(pad_in[1][28:25]))
    else $error("external irq not from its pins");
endmodule

bind pin_mux pin_mux_chk chk_u (.core_clk, .rst_n, .gpio_out, .gpio_oe,
  .func_sel_b, .periph_en, .port_a_func_out, .bcde_func_a_out,
  .bcde_func_b_out, .trace_en, .trace_layout_select, .trace_message_data,
  .trace_message_start_end, .trace_clock_out, .debug_event_out, .pad_in,
  .pad_out, .pad_oe, .pull_en, .line_in, .nmi_n, .external_irq_in);

`default_nettype wire

// ---- test/pin_mux_tb.sv ----
// Self-checking bench for the peripheral pin multiplexer
`timescale 1ns/1ps
`default_nettype none

module pin_mux_tb;
  logic             core_clk, rst_n, trace_en, trace_layout_select;
  logic             trace_clock_out, debug_event_out, nmi_n;
  logic             debug_event_in_pad, debug_event_in;
  logic [5:0]       trace_message_data;
  logic [1:0]       trace_message_start_end;
  logic [3:0]       external_irq_in;
  logic [63:0]      port_a_func_out, port_a_func_oe, port_a_func_in, e;
  logic [4:0][31:0] gpio_out, gpio_oe, pull_req, func_sel_b, periph_en;
  logic [4:0][31:0] pad_in, pad_out, pad_oe, pull_en, line_in;
  logic [4:0][31:0] ext_en, ext_val;
  logic [3:0][31:0] bcde_func_a_out, bcde_func_a_oe;
  logic [3:0][31:0] bcde_func_b_out, bcde_func_b_oe;
  int               miscompares, n_checks, cycles;

  pin_mux dut_u (.core_clk, .rst_n, .gpio_out, .gpio_oe, .pull_req,
    .func_sel_b, .periph_en, .port_a_func_out, .port_a_func_oe,
    .port_a_func_in, .bcde_func_a_out, .bcde_func_a_oe, .bcde_func_b_out,
    .bcde_func_b_oe, .trace_en, .trace_layout_select, .trace_message_data,
    .trace_message_start_end, .trace_clock_out, .debug_event_out,
    .debug_event_in_pad, .debug_event_in, .nmi_n, .external_irq_in,
    .pad_in, .pad_out, .pad_oe, .pull_en, .line_in);
  pad_model model_u (.core_clk, .pad_out, .pad_oe, .pull_en, .ext_en,
    .ext_val, .pad_in);

  initial begin
    core_clk = 0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp,
                       input string what);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Controller drive, then peripherals taking over with mixed selects
  task automatic t_gpio_sel;
    @(posedge core_clk);
    gpio_out[4:3] <= 64'h1234_5678_9ABC_DEF0;
    gpio_oe[4:3]  <= 64'hFFFF_0000_0F0F_F0F0;
    pull_req[4:3] <= 64'h00FF_00FF_F00F_0FF0;
    step(1);
    check(pad_out[4:3], 64'h1234_5678_9ABC_DEF0, "gpio out");
    check(pad_oe[4:3], 64'hFFFF_0000_0F0F_F0F0, "gpio oe");
    check(pull_en[4:3], 64'h00FF_00FF_F00F_0FF0, "pull");
    @(posedge core_clk);
    periph_en[4:3] <= '1;
    func_sel_b[4:3] <= 64'hF0F0_3C3C_0000_FFFF;
    bcde_func_a_out[3:2] <= 64'hAAAA_5555_1111_2222;
    bcde_func_b_out[3:2] <= 64'h5555_AAAA_8888_4444;
    step(1);
    check(pad_out[4:3], 64'h5A5A_6969_1111_4444, "select ab");
    $display("test gpio_sel done");
  endtask

  task automatic t_port_a(input logic sel);
    @(posedge core_clk);
    periph_en[0] <= '1;
    func_sel_b[0] <= {32{sel}};
    port_a_func_out <= 64'hC3A5_0FF0_5AA5_9669;
    port_a_func_oe <= '1;
    ext_en[0] <= '1;
    ext_val[0] <= 32'h6B2D_E417;
    step(1);
    e = sel ? 64'hC3A5_0FF0 : 64'h5AA5_9669;
    check(pad_out[0][15:0], e[15:0], "port a low");
    check(pad_out[0][31:16], e[31:16], "port a high");
    @(posedge core_clk);
    port_a_func_oe <= '0;
    step(2);
    e = sel ? {32'h6B2D_E417, 32'h0} : 64'h6B2D_E417;
    check(port_a_func_in, e, "port a in");
    $display("test port_a done");
  endtask

  task automatic t_trace(input logic lay);
    @(posedge core_clk);
    periph_en[2:1] <= '1;
    bcde_func_a_out[1:0] <= '0;
    bcde_func_a_oe[1:0] <= '0;
    trace_en <= 1'b1;
    trace_layout_select <= lay;
    trace_message_data <= 6'b10_1101;
    trace_message_start_end <= 2'b10;
    trace_clock_out <= 1'b1;
    step(1);
    e = lay ? '0 : 64'h2D6;
    check(pad_out[1][9:0], e, "layout b pins");
    check({pad_oe[1][28], pad_oe[1][3]}, lay ? 2'b10 : 2'b01, "trace oe");
    e = {pad_out[2][18], pad_out[2][14], pad_out[2][12], pad_out[2][11],
      pad_out[2][6], pad_out[2][5], pad_out[1][28], pad_out[2][2:0]};
    check(e, lay ? 64'h2D6 : '0, "layout c pins");
    @(posedge core_clk);
    trace_en <= 1'b0;
    $display("test trace done");
  endtask

  task automatic t_irq(input logic [31:0] v, input logic [3:0] irq);
    @(posedge core_clk);
    periph_en[1] <= '0;
    gpio_oe[1] <= '0;
    ext_en[1] <= '1;
    ext_val[1] <= v;
    debug_event_in_pad <= v[24];
    step(2);
    check(nmi_n, v[24], "nmi");
    check(external_irq_in, irq, "ext irq");
    check(line_in[1], v, "line in");
    check(debug_event_in, v[24], "event in");
    $display("test irq done");
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      stop_test;
    end
  end

  initial begin
    {rst_n, trace_en, trace_layout_select, trace_clock_out} = '0;
    {debug_event_out, trace_message_data, trace_message_start_end} = '0;
    {gpio_out, gpio_oe, func_sel_b, periph_en, ext_en, ext_val} = '0;
    {bcde_func_a_out, bcde_func_a_oe, bcde_func_b_out} = '0;
    {bcde_func_b_oe, port_a_func_out, port_a_func_oe} = '0;
    pull_req = '1;
    debug_event_in_pad = 1'b1;
    bcde_func_a_oe = '1;
    bcde_func_b_oe = '1;
    step(4);
    check(pull_en[1:0], '1, "reset pull");
    check(pad_oe[1:0], '0, "reset oe");
    @(posedge core_clk);
    rst_n <= 1'b1;
    step(1);
    t_gpio_sel();
    t_port_a(1'b0);
    t_port_a(1'b1);
    t_trace(1'b0);
    t_trace(1'b1);
    t_irq(32'h1200_0000, 4'b1001);
    t_irq(32'h0D00_0000, 4'b0110);
    stop_test();
  end
endmodule

`default_nettype wire
